// [bbx_core.sv]
`timescale 1ns/1ps
`default_nettype none
module bbx_core
	import bbx_pkg::*;
(
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic advance_i,
	input wire logic launch_request_i,
	input wire logic proceed_ack_i,
	output logic inactive_flag_o,
	output logic accept_next_flag_o,
	output logic finish_flag_o,
	input wire logic [DATA_W-1:0] addend_i,
	output logic [DATA_W-1:0] sum_o,
	output logic sum_vld_o,
	input wire logic [DATA_W-1:0] acc_i,
	output logic [DATA_W-1:0] acc_o,
	output logic acc_vld_o,
	input wire logic in_empty_n_i,
	output logic in_read_o,
	input wire logic [DATA_W-1:0] in_data_i,
	input wire logic out_full_n_i,
	output logic out_write_o,
	output logic [DATA_W-1:0] out_data_o,
	output logic [ADDR_W-1:0] sp_addr_o,
	output logic sp_ce_o,
	output logic sp_we_o,
	output logic [DATA_W-1:0] sp_wdata_o,
	input wire logic [DATA_W-1:0] sp_rdata_i,
	output logic [ADDR_W-1:0] dp_addr_o,
	output logic dp_ce_o,
	output logic dp_we_o,
	output logic [DATA_W-1:0] dp_wdata_o,
	input wire logic [DATA_W-1:0] dp_rdata_i,
	output logic [ADDR_W-1:0] dp_addr_snd_o,
	output logic dp_ce_snd_o,
	output logic dp_we_snd_o,
	output logic [DATA_W-1:0] dp_wdata_snd_o,
	input wire logic [DATA_W-1:0] dp_rdata_snd_i
);
	bbx_state_t state_reg;
	bbx_state_t state_next;
	logic [ADDR_W-1:0] idx_reg;
	logic [DATA_W-1:0] word_reg;
	logic [DATA_W-1:0] result_reg;
	logic take_word;
	logic push_fire;
	logic [DATA_W-1:0] acc_next;

	bbx_stream_if #(.WIDTH(DATA_W)) push_if ();
	bbx_stream_if #(.WIDTH(DATA_W)) pop_if ();

	bbx_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.wr(push_if.snk),
		.rd(pop_if.src)
	);

	////////////////////////////////////////////////////////////////////////
	// Decoding shared by several ports
	////////////////////////////////////////////////////////////////////////
	// Memory ports open on a fetch or on a write-back
	function automatic logic port_enable(input logic fetch, input logic store);
		port_enable = fetch || store;
	endfunction : port_enable

	function automatic logic stream_space(input logic have_word, input logic has_room);
		stream_space = have_word && has_room;
	endfunction : stream_space

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	////////////////////////////////////////////////////////////////////////
	assign take_word = (state_reg == ST_READ) && in_empty_n_i;
	// Full FIFO holds the block in the push state
	assign push_fire = (state_reg == ST_PUSH) && push_if.ready;
	assign acc_next = acc_i + result_reg;

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: if (launch_request_i) state_next = ST_READ;
			ST_READ: if (in_empty_n_i) state_next = ST_WAIT;
			ST_WAIT: state_next = ST_CALC;
			ST_CALC: state_next = ST_PUSH;
			ST_PUSH: if (push_if.ready) state_next = ST_DONE;
			// A second launch is refused until the finish is acknowledged
			ST_DONE: if (proceed_ack_i) state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
			state_reg <= ST_IDLE;
		else if (advance_i)
			state_reg <= state_next;
	end

	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			inactive_flag_o <= 1'b1;
			accept_next_flag_o <= 1'b0;
			finish_flag_o <= 1'b0;
		end
		else if (advance_i)
		begin
			inactive_flag_o <= (state_next == ST_IDLE);
			accept_next_flag_o <= (state_reg == ST_IDLE) && launch_request_i;
			finish_flag_o <= (state_next == ST_DONE);
		end
	end

	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
			idx_reg <= IDX_RESET;
		else if (advance_i && push_fire)
			idx_reg <= idx_reg + IDX_STEP;
	end

	////////////////////////////////////////////////////////////////////////
	// Input stream and datapath
	////////////////////////////////////////////////////////////////////////
	// Head word is captured as the pop is issued; the head is stable until then
	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			in_read_o <= 1'b0;
			word_reg <= DATA_RESET;
		end
		else if (advance_i)
		begin
			in_read_o <= take_word;
			if (take_word)
				word_reg <= in_data_i;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
			result_reg <= DATA_RESET;
		else if (advance_i && state_reg == ST_CALC)
			result_reg <= word_reg + addend_i + sp_rdata_i + dp_rdata_i + dp_rdata_snd_i;
	end

	////////////////////////////////////////////////////////////////////////
	// Memories: read while fetching, write back on push
	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			sp_addr_o <= IDX_RESET;
			sp_ce_o <= 1'b0;
			sp_we_o <= 1'b0;
			sp_wdata_o <= DATA_RESET;
		end
		else if (advance_i)
		begin
			sp_ce_o <= port_enable(take_word, push_fire);
			sp_we_o <= push_fire;
			if (take_word)
				sp_addr_o <= idx_reg;
			if (push_fire)
				sp_wdata_o <= result_reg;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			dp_addr_o <= IDX_RESET;
			dp_ce_o <= 1'b0;
			dp_we_o <= 1'b0;
			dp_wdata_o <= DATA_RESET;
			dp_addr_snd_o <= IDX_RESET;
			dp_ce_snd_o <= 1'b0;
			dp_we_snd_o <= 1'b0;
			dp_wdata_snd_o <= DATA_RESET;
		end
		else if (advance_i)
		begin
			dp_ce_o <= port_enable(take_word, push_fire);
			dp_we_o <= push_fire;
			dp_ce_snd_o <= port_enable(take_word, push_fire);
			dp_we_snd_o <= push_fire;
			if (take_word)
			begin
				dp_addr_o <= idx_reg;
				dp_addr_snd_o <= idx_reg + IDX_STEP;
			end
			if (push_fire)
			begin
				dp_wdata_o <= result_reg;
				dp_wdata_snd_o <= acc_next;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Strobed arguments
	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			sum_o <= DATA_RESET;
			sum_vld_o <= 1'b0;
			acc_o <= DATA_RESET;
			acc_vld_o <= 1'b0;
		end
		else if (advance_i)
		begin
			sum_vld_o <= push_fire;
			acc_vld_o <= push_fire;
			if (push_fire)
			begin
				sum_o <= result_reg;
				acc_o <= acc_next;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output stream through the FIFO
	////////////////////////////////////////////////////////////////////////
	assign push_if.valid = (state_reg == ST_PUSH) && advance_i;
	assign push_if.data = result_reg;
	assign pop_if.ready = advance_i && out_full_n_i;

	// Registered write needs one word of slack after full_n drops
	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			out_write_o <= 1'b0;
			out_data_o <= DATA_RESET;
		end
		else if (advance_i)
		begin
			out_write_o <= stream_space(pop_if.valid, out_full_n_i);
			if (stream_space(pop_if.valid, out_full_n_i))
				out_data_o <= pop_if.data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	////////////////////////////////////////////////////////////////////////
	logic [7:0] run_cnt_reg;

	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
			run_cnt_reg <= 8'h00;
		else if (advance_i && state_reg == ST_IDLE && launch_request_i)
			run_cnt_reg <= 8'h01;
		else if (advance_i && state_reg != ST_IDLE && state_reg != ST_DONE && run_cnt_reg != 8'hff)
			run_cnt_reg <= run_cnt_reg + 8'h01;
	end

	logic wait_seen_reg;

	// Exact latency only holds for a run that never waited on data or space
	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
			wait_seen_reg <= 1'b0;
		else if (advance_i && state_reg == ST_IDLE && launch_request_i)
			wait_seen_reg <= 1'b0;
		else if (advance_i && ((state_reg == ST_READ && !in_empty_n_i) ||
			(state_reg == ST_PUSH && !push_if.ready)))
			wait_seen_reg <= 1'b1;
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	AST_FINISH_PENDING: assert property (finish_flag_o && !(advance_i && proceed_ack_i) |=> finish_flag_o)
		else $error("finish dropped before proceed acknowledge");
	AST_STALL_HOLD: assert property (!advance_i |=> $stable({inactive_flag_o, accept_next_flag_o, finish_flag_o,
		sum_vld_o, acc_vld_o, in_read_o, out_write_o, sp_ce_o, sp_we_o, dp_ce_o, dp_we_o, dp_ce_snd_o, dp_we_snd_o}))
		else $error("outputs moved while stalled");
	AST_LATENCY: assert property ($rose(finish_flag_o) |-> run_cnt_reg >= LATENCY)
		else $error("finish earlier than fixed latency");
	AST_READ_NONEMPTY: assert property ($rose(in_read_o) |-> $past(in_empty_n_i) && $past(advance_i))
		else $error("stream read without data");
	AST_WRITE_NOTFULL: assert property ($rose(out_write_o) |-> $past(out_full_n_i))
		else $error("stream write while full");
	AST_ACC_SUM: assert property ($rose(acc_vld_o) |-> acc_o == $past(acc_i) + sum_o)
		else $error("written-back value mismatch");
	AST_STROBE_PULSE: assert property (sum_vld_o && advance_i |=> !sum_vld_o ##1 1'b1)
		else $error("output strobe longer than one cycle");
	AST_SP_WRITE: assert property (sp_we_o |-> sp_ce_o && sum_vld_o && sp_wdata_o == sum_o)
		else $error("single-port write without enable");
	AST_DP_WRITE: assert property (dp_we_snd_o |-> dp_ce_snd_o && dp_we_o && dp_wdata_snd_o == acc_o)
		else $error("second port write mismatch");
	AST_IDLE_FLAGS: assert property (inactive_flag_o |-> !finish_flag_o && !sum_vld_o)
		else $error("inactive while finishing");
	AST_ACCEPT_TO_READ: assert property (accept_next_flag_o |-> !inactive_flag_o)
		else $error("accepted but still inactive");
	// Stall holds strobes high, so pulse checks only look across advancing edges
	AST_SERIAL_ISSUE: assert property ((ISSUE_INTERVAL == 0) && accept_next_flag_o && advance_i |=> !accept_next_flag_o)
		else $error("second launch accepted back to back");
	AST_REFUSE_BUSY: assert property (!inactive_flag_o && advance_i |=> !accept_next_flag_o)
		else $error("launch accepted while busy");
	AST_INACTIVE_HOLD: assert property (inactive_flag_o && advance_i && !launch_request_i |=> inactive_flag_o)
		else $error("inactive dropped without a launch");
	AST_ACCEPT_CAUSE: assert property ($rose(accept_next_flag_o) |-> $past(launch_request_i) && $past(inactive_flag_o))
		else $error("accept without a launch in idle");
	AST_READ_PULSE: assert property (in_read_o && advance_i |=> !in_read_o)
		else $error("stream read longer than one cycle");
	AST_MEM_FETCH_PULSE: assert property (sp_ce_o && !sp_we_o && advance_i |=> !sp_ce_o)
		else $error("memory fetch enable longer than one cycle");
	AST_FETCH_TOGETHER: assert property (sp_ce_o && !sp_we_o |-> in_read_o && dp_ce_o && dp_ce_snd_o && !dp_we_o)
		else $error("memory fetch ports out of step");
	AST_FINISH_STROBES: assert property ($rose(finish_flag_o) |-> sum_vld_o && acc_vld_o && sp_we_o && dp_we_o)
		else $error("finish without its write strobes");
	AST_PROCEED_CLEAR: assert property (finish_flag_o && advance_i && proceed_ack_i |=> !finish_flag_o && inactive_flag_o)
		else $error("finish kept after proceed acknowledge");
	AST_PUSH_BLOCKED: assert property (state_reg == ST_PUSH && !push_if.ready |-> !finish_flag_o && !sum_vld_o)
		else $error("result delivered while buffer full");
	AST_STALL_DATA: assert property (!advance_i |=> $stable({sum_o, acc_o, out_data_o, sp_addr_o, sp_wdata_o,
		dp_addr_o, dp_wdata_o, dp_addr_snd_o, dp_wdata_snd_o}))
		else $error("data outputs moved while stalled");
	AST_LATENCY_EXACT: assert property ($rose(finish_flag_o) && !wait_seen_reg |-> run_cnt_reg == 8'(LATENCY))
		else $error("latency differs from the fixed figure");

	CV_FINISH: cover property ($rose(finish_flag_o));
	CV_STREAM_OUT: cover property (out_write_o ##1 out_write_o);
	CV_STALL_PENDING: cover property (finish_flag_o && !advance_i ##1 finish_flag_o);
	CV_BACK_TO_BACK: cover property (finish_flag_o && advance_i && proceed_ack_i ##1 inactive_flag_o ##1 accept_next_flag_o);
	CV_REFUSED_LAUNCH: cover property (launch_request_i && !inactive_flag_o && advance_i);
endmodule : bbx_core
`default_nettype wire

// [bbx_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module bbx_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic clock_i,
	input wire logic reset_i,
	bbx_stream_if.snk wr,
	bbx_stream_if.src rd
);
	localparam int PTR_W = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_arr [DEPTH];
	logic [PTR_W:0] wr_ptr_reg;
	logic [PTR_W:0] rd_ptr_reg;
	logic empty;
	logic full;

	// Extra pointer bit tells full from empty without a counter
	assign empty = (wr_ptr_reg == rd_ptr_reg);
	assign full = (wr_ptr_reg[PTR_W] != rd_ptr_reg[PTR_W]) &&
		(wr_ptr_reg[PTR_W-1:0] == rd_ptr_reg[PTR_W-1:0]);
	assign wr.ready = !full;
	assign rd.valid = !empty;
	assign rd.data = mem_arr[rd_ptr_reg[PTR_W-1:0]];

	always_ff @(posedge clock_i)
	begin
		if (wr.valid && !full)
			mem_arr[wr_ptr_reg[PTR_W-1:0]] <= wr.data;
	end

	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
			wr_ptr_reg <= '0;
		else if (wr.valid && !full)
			wr_ptr_reg <= wr_ptr_reg + 1'b1;
	end

	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
			rd_ptr_reg <= '0;
		else if (rd.ready && !empty)
			rd_ptr_reg <= rd_ptr_reg + 1'b1;
	end
endmodule : bbx_fifo
`default_nettype wire

// [bbx_parent_model.sv]
`timescale 1ns/1ps
`default_nettype none
module bbx_parent_model
	import bbx_pkg::*;
(
	input wire logic clock_i,
	input wire logic ce_i,
	output logic empty_n_o,
	input wire logic read_i,
	output logic [DATA_W-1:0] rdata_o,
	input wire logic write_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic [ADDR_W-1:0] sp_addr_i,
	input wire logic sp_ce_i,
	input wire logic sp_we_i,
	input wire logic [DATA_W-1:0] sp_wdata_i,
	output logic [DATA_W-1:0] sp_rdata_o,
	input wire logic [ADDR_W-1:0] a_addr_i,
	input wire logic a_ce_i,
	input wire logic a_we_i,
	input wire logic [DATA_W-1:0] a_wdata_i,
	output logic [DATA_W-1:0] a_rdata_o,
	input wire logic [ADDR_W-1:0] b_addr_i,
	input wire logic b_ce_i,
	input wire logic b_we_i,
	input wire logic [DATA_W-1:0] b_wdata_i,
	output logic [DATA_W-1:0] b_rdata_o
);
	logic [DATA_W-1:0] sp_mem [16];
	logic [DATA_W-1:0] dp_mem [16];
	logic [DATA_W-1:0] src_q [$];
	logic [DATA_W-1:0] sink_q [$];
	////////////////////////////////////////
	// Strobes gated by our own enable: held pulses must not pop twice
	always @(posedge clock_i)
	begin
		if (ce_i && read_i && src_q.size() > 0)
			void'(src_q.pop_front());
		empty_n_o <= src_q.size() > 0;
		rdata_o <= (src_q.size() > 0) ? src_q[0] : ~rdata_o;
		if (ce_i && write_i)
			sink_q.push_back(wdata_i);
	end
	////////////////////////////////////////
	// Read data lives one cycle, then scrambles
	always @(posedge clock_i)
	begin
		if (sp_ce_i && sp_we_i)
			sp_mem[sp_addr_i] <= sp_wdata_i;
		sp_rdata_o <= sp_ce_i ? sp_mem[sp_addr_i] : ~sp_rdata_o;
		if (a_ce_i && a_we_i)
			dp_mem[a_addr_i] <= a_wdata_i;
		if (b_ce_i && b_we_i)
			dp_mem[b_addr_i] <= b_wdata_i;
		a_rdata_o <= a_ce_i ? dp_mem[a_addr_i] : ~a_rdata_o;
		b_rdata_o <= b_ce_i ? dp_mem[b_addr_i] : ~b_rdata_o;
	end
endmodule : bbx_parent_model
`default_nettype wire

// [bbx_pkg.sv]
`default_nettype none
package bbx_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 4;
	localparam int FIFO_DEPTH = 8;
	localparam int LATENCY = 5;
	localparam int ISSUE_INTERVAL = 0;
	localparam logic [ADDR_W-1:0] IDX_RESET = 4'h0;
	localparam logic [ADDR_W-1:0] IDX_STEP = 4'h1;
	localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_READ = 3'b001,
		ST_WAIT = 3'b010,
		ST_CALC = 3'b011,
		ST_PUSH = 3'b100,
		ST_DONE = 3'b101
	} bbx_state_t;
endpackage : bbx_pkg
`default_nettype wire

// [bbx_stream_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface bbx_stream_if #(parameter int WIDTH = 16);
	logic [WIDTH-1:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : bbx_stream_if
`default_nettype wire

// [rtl_blackbox_interface_test.sv]
`timescale 1ns/1ps
`default_nettype none
module rtl_blackbox_interface_test
	import bbx_pkg::*;
;
	int miscompares = 0;
	int compares = 0;
	int n;
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	logic advance_i = 1'b0;
	logic launch_request_i = 1'b0;
	logic proceed_ack_i = 1'b0;
	logic out_full_n_i = 1'b1;
	logic [DATA_W-1:0] addend_i = 16'h0000;
	logic [DATA_W-1:0] acc_i = 16'h0000;
	logic inactive_flag_o, accept_next_flag_o, finish_flag_o, sum_vld_o, acc_vld_o, in_read_o, out_write_o;
	logic sp_ce_o, sp_we_o, dp_ce_o, dp_we_o, dp_ce_snd_o, dp_we_snd_o, in_empty_n_i;
	logic [DATA_W-1:0] sum_o, acc_o, in_data_i, out_data_o, sp_wdata_o, sp_rdata_i;
	logic [DATA_W-1:0] dp_wdata_o, dp_rdata_i, dp_wdata_snd_o, dp_rdata_snd_i, res;
	logic [ADDR_W-1:0] sp_addr_o, dp_addr_o, dp_addr_snd_o;
	logic [ADDR_W-1:0] idx = 4'h0;
	logic [DATA_W-1:0] exp_sp [16];
	logic [DATA_W-1:0] exp_dp [16];
	logic [DATA_W-1:0] exp_q [$];

	always #25 clock_i = ~clock_i;

	bbx_core dut_u (.clock_i, .reset_i, .advance_i, .launch_request_i, .proceed_ack_i, .inactive_flag_o,
		.accept_next_flag_o, .finish_flag_o, .addend_i, .sum_o, .sum_vld_o, .acc_i, .acc_o, .acc_vld_o,
		.in_empty_n_i, .in_read_o, .in_data_i, .out_full_n_i, .out_write_o, .out_data_o, .sp_addr_o,
		.sp_ce_o, .sp_we_o, .sp_wdata_o, .sp_rdata_i, .dp_addr_o, .dp_ce_o, .dp_we_o, .dp_wdata_o,
		.dp_rdata_i, .dp_addr_snd_o, .dp_ce_snd_o, .dp_we_snd_o, .dp_wdata_snd_o, .dp_rdata_snd_i);

	bbx_parent_model model_u (.clock_i(clock_i), .ce_i(advance_i), .empty_n_o(in_empty_n_i),
		.read_i(in_read_o), .rdata_o(in_data_i), .write_i(out_write_o), .wdata_i(out_data_o),
		.sp_addr_i(sp_addr_o), .sp_ce_i(sp_ce_o), .sp_we_i(sp_we_o), .sp_wdata_i(sp_wdata_o),
		.sp_rdata_o(sp_rdata_i), .a_addr_i(dp_addr_o), .a_ce_i(dp_ce_o), .a_we_i(dp_we_o),
		.a_wdata_i(dp_wdata_o), .a_rdata_o(dp_rdata_i), .b_addr_i(dp_addr_snd_o), .b_ce_i(dp_ce_snd_o),
		.b_we_i(dp_we_snd_o), .b_wdata_i(dp_wdata_snd_o), .b_rdata_o(dp_rdata_snd_i));
	////////////////////////////////////////
	task automatic tick(input int k);
		repeat (k) @(posedge clock_i);
		#1;
	endtask : tick

	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
		compares++;
		if (seen !== want)
		begin
			miscompares++;
			$display("ERROR at %0t: saw %h, expected %h", $time, seen, want);
		end
	endtask : check

	task automatic report_and_stop();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop

	task automatic start(input logic [DATA_W-1:0] w, input bit push);
		if (push)
			model_u.src_q.push_back(w);
		res = w + addend_i + exp_sp[idx] + exp_dp[idx] + exp_dp[idx + 4'h1];
		launch_request_i = 1'b1;
		tick(1);
		launch_request_i = 1'b0;
		check(accept_next_flag_o, 1'b1);
		check(inactive_flag_o, 1'b0);
	endtask : start

	task automatic wait_fin(input int lim);
		n = 1;
		while (finish_flag_o !== 1'b1 && n < lim)
		begin
			tick(1);
			n++;
		end
	endtask : wait_fin

	// Latency checked only where no wait on data or space is involved
	task automatic finish_run(input int lat);
		if (lat > 0)
			check(16'(n), 16'(lat));
		check(sum_o, res);
		check({sum_vld_o, acc_vld_o}, 16'h0003);
		check(acc_o, acc_i + res);
		tick(2);
		check({finish_flag_o, sum_vld_o}, 16'h0002);
		proceed_ack_i = 1'b1;
		tick(1);
		proceed_ack_i = 1'b0;
		check({finish_flag_o, inactive_flag_o}, 16'h0001);
		check(model_u.sp_mem[idx], res);
		check(model_u.dp_mem[idx], res);
		check(model_u.dp_mem[idx + 4'h1], acc_i + res);
		exp_sp[idx] = res;
		exp_dp[idx] = res;
		exp_dp[idx + 4'h1] = acc_i + res;
		exp_q.push_back(res);
		idx++;
	endtask : finish_run

	task automatic drain_check();
		tick(12);
		check(16'(model_u.sink_q.size()), 16'(exp_q.size()));
		while (exp_q.size() > 0 && model_u.sink_q.size() > 0)
			check(model_u.sink_q.pop_front(), exp_q.pop_front());
		exp_q.delete();
		model_u.sink_q.delete();
	endtask : drain_check
	////////////////////////////////////////
	task automatic t_reset();
		check(inactive_flag_o, 1'b1);
		check({accept_next_flag_o, finish_flag_o, sum_vld_o, acc_vld_o, in_read_o, out_write_o}, 16'h0000);
		check({sp_ce_o, sp_we_o, dp_ce_o, dp_we_o, dp_ce_snd_o, dp_we_snd_o}, 16'h0000);
		$display("reset test done");
	endtask : t_reset

	task automatic t_basic();
		// Wrapping addend, back-to-back launches
		addend_i = 16'hffff;
		acc_i = 16'h0f0f;
		for (int k = 0; k < 2; k++)
		begin
			start(16'h0100 + 16'(k), 1'b1);
			wait_fin(20);
			finish_run(LATENCY);
		end
		drain_check();
		$display("basic test done");
	endtask : t_basic

	task automatic t_stall();
		start(16'h4321, 1'b1);
		tick(1);
		advance_i = 1'b0;
		tick(4);
		check({in_read_o, sp_ce_o, dp_ce_o, dp_ce_snd_o, inactive_flag_o}, 16'h001e);
		advance_i = 1'b1;
		wait_fin(20);
		finish_run(LATENCY - 1);
		drain_check();
		$display("stall test done");
	endtask : t_stall

	task automatic t_empty();
		start(16'h0abc, 1'b0);
		tick(1);
		// Launches while busy must be refused
		launch_request_i = 1'b1;
		tick(7);
		check({finish_flag_o, in_read_o, accept_next_flag_o, inactive_flag_o}, 16'h0000);
		launch_request_i = 1'b0;
		model_u.src_q.push_back(16'h0abc);
		wait_fin(20);
		finish_run(0);
		drain_check();
		$display("empty test done");
	endtask : t_empty

	task automatic t_fifo();
		out_full_n_i = 1'b0;
		for (int k = 0; k < FIFO_DEPTH; k++)
		begin
			start(16'h2000 + 16'(k), 1'b1);
			wait_fin(20);
			finish_run(LATENCY);
		end
		check(out_write_o, 1'b0);
		start(16'h3000, 1'b1);
		tick(10);
		check(finish_flag_o, 1'b0);
		// Far side blinks its space flag while we drain
		// Stop at the finish so its one-cycle strobes are still seen
		repeat (12)
		begin
			out_full_n_i = ~out_full_n_i;
			tick(1);
			if (finish_flag_o === 1'b1)
				break;
		end
		out_full_n_i = 1'b1;
		wait_fin(30);
		finish_run(0);
		drain_check();
		$display("fifo test done");
	endtask : t_fifo
	////////////////////////////////////////
	initial
	begin
		for (int i = 0; i < 16; i++)
		begin
			exp_sp[i] = 16'h0011 * 16'(i);
			exp_dp[i] = 16'h0300 + 16'(i);
			model_u.sp_mem[i] = exp_sp[i];
			model_u.dp_mem[i] = exp_dp[i];
		end
		tick(10);
		t_reset();
		reset_i = 1'b0;
		advance_i = 1'b1;
		t_reset();
		t_basic();
		t_stall();
		t_empty();
		t_fifo();
		report_and_stop();
	end

	initial
	begin
		#150000;
		miscompares++;
		report_and_stop();
	end
endmodule : rtl_blackbox_interface_test
`default_nettype wire
